// ### gpt_pkg.sv
/*
  Shared constants for the general-purpose timer block: register map,
  control field positions, reset values, prescale limits and mode codes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package gpt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int NUM_TMR = 5;
  localparam int ADDR_W = 8;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_COUNT = 4'h4;
  localparam logic [3:0] OFS_PERIOD = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h50;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE = 13;
  localparam int BIT_GATE = 6;
  localparam int PS_HI = 5;
  localparam int PS_LO = 4;
  localparam int BIT_CMB = 3;
  localparam int BIT_SYNC = 2;
  localparam int BIT_SRC = 1;
  localparam logic [15:0] MASK_SOLO = 16'hA076;
  localparam logic [15:0] MASK_LOW = 16'hA07A;
  localparam logic [15:0] MASK_HIGH = 16'hA072;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Prescale terminal counts (divide minus one)
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_CODE_1 = 2'b00;
  localparam logic [1:0] PS_CODE_8 = 2'b01;
  localparam logic [1:0] PS_CODE_64 = 2'b10;
  localparam logic [1:0] PS_CODE_256 = 2'b11;
  localparam logic [7:0] PS_LIM_1 = 8'h00;
  localparam logic [7:0] PS_LIM_8 = 8'h07;
  localparam logic [7:0] PS_LIM_64 = 8'h3F;
  localparam logic [7:0] PS_LIM_256 = 8'hFF;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_GATED,
    MODE_SYNC_CNT,
    MODE_ASYNC_CNT
  } gpt_mode_t;

endpackage

// ### gpt_timers.sv
/*
  General-purpose timers: one standalone 16-bit timer (index 0) and two
  pairs (indices 1/2 and 3/4) that run as 16-bit halves or one 32-bit timer,
  with an AXI4-Lite register slave.
  Assumes pins are synchronous to mclk and the instruction clock is mclk.
*/
// Summary of operation
// (R01) Standalone timer is a 16-bit free-running or interval timer/counter.
// (R02) Standalone control: source at bit 1, sync at bit 2, gating at bit 6.
// (R03) Mode from source, gating and sync: timer, gated, sync counter, async counter.
// (R04) Timer and gated modes count the internal instruction clock.
// (R05) Counter modes count rising edges of the external clock pin.
// (R06) Run bit 15 starts the timer when set, stops it when clear.
// (R07) Idle-stop bit 13 halts the timer in Idle mode; clear keeps it running.
// (R08) Gating works only with internal source; ignored with external source.
// (R09) Prescale codes 00,01,10,11 divide by 1, 8, 64, 256.
// (R10) Sync bit chooses external input synchronisation; ignored with internal source.
// (R11) Synchronisation of the external clock happens after the prescaler.
// (R12) Count writes are ignored while standalone runs as synchronous counter.
// (R13) Each pair runs as one 32-bit timer or two 16-bit timers.
// (R14) Paired 16-bit halves support every mode except asynchronous counting.
// (R15) Each paired timer can run alone as synchronous timer or counter.
// (R16) In 32-bit mode even timer is low word, odd timer high word.
// (R17) In 32-bit mode only even control configures; odd control ignored.
// (R18) 32-bit pair uses even clock and gate, flags through odd timer.
// (R19) 32-bit pair interrupts when its 32-bit count matches its period.
// (R20) Only the first pair drives the ADC conversion trigger.
// (R21) Paired timers request DMA; the standalone timer does not.
// (R22) Even control bit 3 combines the pair into a 32-bit timer.
// (R23) On count-period match the count returns to zero and the flag sets.
`timescale 1ns/1ps
`default_nettype none

module gpt_timers
  import gpt_pkg::*;
(
  input wire logic mclk, // 200 MHz clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic idleMode, // Device is in Idle mode
  input wire logic [NUM_TMR-1:0] extClkPin, // External clock pins
  input wire logic [NUM_TMR-1:0] gatePin, // Gate inputs for gated mode
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic [NUM_TMR-1:0] tmrFlag, // Sticky match flags
  output logic [3:0] dmaReq, // DMA request pulses, paired timers
  output logic adcTrig // ADC trigger pulse, first pair
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q [NUM_TMR];
  logic [15:0] cnt_q [NUM_TMR];
  logic [15:0] per_q [NUM_TMR];
  logic [NUM_TMR-1:0] flag_q;
  logic [NUM_TMR-1:0] pinPrev_q;
  logic [3:0] dma_q;
  logic adc_q;
  logic [NUM_TMR-1:0] tick;
  logic [NUM_TMR-1:0] setEvt;
  logic [NUM_TMR-1:0] cntWr;
  logic [NUM_TMR-1:0] ctrlWr;
  logic [NUM_TMR-1:0] perWr;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;

  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
    mergeLanes = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  wire awFire = s_axi_awvalid && awready_q;
  wire wFire = s_axi_wvalid && wready_q;
  // Both halves held and no response pending: the write happens now
  wire doWrite = !awready_q && !wready_q && !bvalid_q;
  wire [2:0] wrIdx = awAddr_q[6:4];
  wire [3:0] wrOfs = awAddr_q[3:0];
  wire wrIdxOk = !awAddr_q[7] && (wrIdx < 3'd5);
  wire wrStatus = (awAddr_q == ADDR_STATUS);
  wire wrHit = wrStatus || (wrIdxOk && (wrOfs == OFS_CTRL || wrOfs == OFS_COUNT
                                        || wrOfs == OFS_PERIOD));
  wire [NUM_TMR-1:0] flagClr = (doWrite && wrStatus && wStrb_q[0]) ?
                               wData_q[NUM_TMR-1:0] : '0;

  wire [2:0] rdIdx = s_axi_araddr[6:4];
  wire [3:0] rdOfs = s_axi_araddr[3:0];
  wire rdIdxOk = !s_axi_araddr[7] && (rdIdx < 3'd5);
  wire rdStatus = (s_axi_araddr == ADDR_STATUS);
  wire rdCtrl = rdIdxOk && (rdOfs == OFS_CTRL);
  wire rdCount = rdIdxOk && (rdOfs == OFS_COUNT);
  wire rdPeriod = rdIdxOk && (rdOfs == OFS_PERIOD);
  wire rdHit = rdStatus || rdCtrl || rdCount || rdPeriod;
  wire [15:0] rdWord = rdCtrl ? ctrl_q[rdIdx] : rdCount ? cnt_q[rdIdx] :
                       rdPeriod ? per_q[rdIdx] : 16'h0000;
  wire [31:0] rdVal = rdStatus ? {27'h000_0000, flag_q} : {16'h0000, rdWord};

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awAddr_q <= '0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end
    else
    begin
      if (awFire)
      begin
        awready_q <= 1'b0;
        awAddr_q <= s_axi_awaddr;
      end
      if (wFire)
      begin
        wready_q <= 1'b0;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdVal;
      rresp_q <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock selection, prescaler and synchroniser per timer
  // ----------------------------------------------------------------
  gpt_mode_t mode [NUM_TMR];

  for (genvar i = 0; i < NUM_TMR; i++)
  begin : g_tmr
    localparam int LO = (i == 2 || i == 4) ? i - 1 : i;
    localparam bit HI = (i == 2 || i == 4);
    localparam logic [15:0] MASK = (i == 0) ? MASK_SOLO : HI ? MASK_HIGH : MASK_LOW;
    logic [7:0] pre_q;
    logic tgl_q, sync1_q, sync2_q, sync3_q;
    logic srcPulse;
    logic [7:0] psLim;
    wire [15:0] cfg = ctrl_q[i];
    wire run = cfg[BIT_RUN] && !(cfg[BIT_IDLE] && idleMode); // see (R06) see (R07)
    // Paired halves have no unsynchronised path
    wire syncOn = (i == 0) ? cfg[BIT_SYNC] : 1'b1; // see (R10) see (R14) see (R15)
    wire pinEdge = extClkPin[i] && !pinPrev_q[i]; // see (R05)
    wire preOut = run && srcPulse && (pre_q == psLim);
    wire syncEdge = sync2_q ^ sync3_q;

    assign mode[i] = !cfg[BIT_SRC] ? (cfg[BIT_GATE] ? MODE_GATED : MODE_TIMER) :
                     (syncOn ? MODE_SYNC_CNT : MODE_ASYNC_CNT); // see (R02) see (R03) see (R08)

    always_comb
    begin
      unique case (mode[i])
        MODE_TIMER: srcPulse = 1'b1; // see (R04)
        MODE_GATED: srcPulse = gatePin[i];
        MODE_SYNC_CNT: srcPulse = pinEdge;
        MODE_ASYNC_CNT: srcPulse = pinEdge;
      endcase
    end

    always_comb
    begin
      unique case (cfg[PS_HI:PS_LO]) // see (R09)
        PS_CODE_1: psLim = PS_LIM_1;
        PS_CODE_8: psLim = PS_LIM_8;
        PS_CODE_64: psLim = PS_LIM_64;
        PS_CODE_256: psLim = PS_LIM_256;
      endcase
    end

    // Prescaled event crosses as a toggle so no edge is lost at 1:1
    always_ff @(posedge mclk)
    begin
      if (sys_rst || !run)
        pre_q <= 8'h00;
      else if (srcPulse)
        pre_q <= preOut ? 8'h00 : pre_q + 8'h01;
    end

    always_ff @(posedge mclk)
    begin
      if (sys_rst)
      begin
        tgl_q <= 1'b0;
        sync1_q <= 1'b0;
        sync2_q <= 1'b0;
        sync3_q <= 1'b0;
      end
      else
      begin
        tgl_q <= tgl_q ^ preOut;
        sync1_q <= tgl_q; // see (R11)
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
      end
    end

    assign tick[i] = (mode[i] == MODE_SYNC_CNT) ? (syncEdge && run) : preOut;

    // --------------------------------------------------------------
    // Count, period and control registers
    // --------------------------------------------------------------
    wire wide = (i != 0) && ctrl_q[LO][BIT_CMB]; // see (R13) see (R22)
    wire match32 = ({cnt_q[LO+1], cnt_q[LO]} == {per_q[LO+1], per_q[LO]}); // see (R19)
    wire effTick = wide ? tick[LO] : tick[i]; // see (R17) see (R18)
    wire match = wide ? match32 : (cnt_q[i] == per_q[i]);
    wire carry = (wide && HI) ? (cnt_q[LO] == COUNT_MAX) : 1'b1; // see (R16)
    wire wrBlock = (i == 0) && cfg[BIT_RUN] && (mode[i] == MODE_SYNC_CNT); // see (R12)

    assign cntWr[i] = doWrite && wrIdxOk && (wrIdx == 3'(i)) && (wrOfs == OFS_COUNT);
    assign ctrlWr[i] = doWrite && wrIdxOk && (wrIdx == 3'(i)) && (wrOfs == OFS_CTRL);
    assign perWr[i] = doWrite && wrIdxOk && (wrIdx == 3'(i)) && (wrOfs == OFS_PERIOD);
    assign setEvt[i] = effTick && match && (!wide || HI); // see (R18) see (R23)

    always_ff @(posedge mclk)
    begin
      if (sys_rst)
        cnt_q[i] <= COUNT_RST;
      else if (cntWr[i] && !wrBlock)
        cnt_q[i] <= mergeLanes(cnt_q[i], wData_q, wStrb_q);
      else if (effTick)
        cnt_q[i] <= match ? COUNT_RST : cnt_q[i] + {15'h0000, carry}; // see (R01) see (R23)
    end

    always_ff @(posedge mclk)
    begin
      if (sys_rst)
      begin
        ctrl_q[i] <= CTRL_RST;
        per_q[i] <= PERIOD_RST;
      end
      else
      begin
        if (ctrlWr[i])
          ctrl_q[i] <= mergeLanes(ctrl_q[i], wData_q, wStrb_q) & MASK;
        if (perWr[i])
          per_q[i] <= mergeLanes(per_q[i], wData_q, wStrb_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and event outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      flag_q <= '0;
      pinPrev_q <= '0;
      dma_q <= 4'h0;
      adc_q <= 1'b0;
    end
    else
    begin
      flag_q <= setEvt | (flag_q & ~flagClr); // Set wins over clear
      pinPrev_q <= extClkPin;
      dma_q <= setEvt[4:1]; // see (R21)
      adc_q <= setEvt[2]; // see (R20)
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign tmrFlag = flag_q;
  assign dmaReq = dma_q;
  assign adcTrig = adc_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_stop_holds;
    !ctrl_q[0][BIT_RUN] && !cntWr[0] |=> $stable(cnt_q[0]);
  endproperty
  a_stop_holds: assert property (p_stop_holds) else $error("stopped timer moved"); // see (R06)

  property p_idle_holds;
    ctrl_q[0][BIT_IDLE] && idleMode && !cntWr[0] |=> $stable(cnt_q[0]);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("timer ran in idle"); // see (R07)

  property p_timer_inc;
    ctrl_q[0][BIT_RUN] && !idleMode && mode[0] == MODE_TIMER
      && ctrl_q[0][PS_HI:PS_LO] == PS_CODE_1 && !cntWr[0] && cnt_q[0] != per_q[0]
      |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001;
  endproperty
  a_timer_inc: assert property (p_timer_inc) else $error("timer did not count"); // see (R04)

  property p_div8;
    tick[0] && mode[0] == MODE_TIMER && ctrl_q[0][PS_HI:PS_LO] == PS_CODE_8
      && !ctrlWr[0] |=> !tick[0] [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("prescale 8 ticked early"); // see (R09)

  wire pinEdge0 = extClkPin[0] && !pinPrev_q[0];

  property p_sync_delay;
    pinEdge0 && mode[0] == MODE_SYNC_CNT && ctrl_q[0][PS_HI:PS_LO] == PS_CODE_1
      && ctrl_q[0][BIT_RUN] && !idleMode && !ctrlWr[0] |-> ##3 tick[0];
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync path delay wrong"); // see (R11)

  property p_async_now;
    pinEdge0 && mode[0] == MODE_ASYNC_CNT && ctrl_q[0][PS_HI:PS_LO] == PS_CODE_1
      && ctrl_q[0][BIT_RUN] && !idleMode |-> tick[0];
  endproperty
  a_async_now: assert property (p_async_now) else $error("async edge missed"); // see (R05)

  property p_wr_ignored;
    cntWr[0] && ctrl_q[0][BIT_RUN] && mode[0] == MODE_SYNC_CNT && !tick[0]
      |=> $stable(cnt_q[0]);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("sync count write taken"); // see (R12)

  property p_match16;
    tick[0] && cnt_q[0] == per_q[0] && !cntWr[0] |=> cnt_q[0] == COUNT_RST && flag_q[0];
  endproperty
  a_match16: assert property (p_match16) else $error("match did not wrap"); // see (R23)

  property p_carry32;
    ctrl_q[1][BIT_CMB] && tick[1] && cnt_q[1] == COUNT_MAX && !setEvt[2]
      && !cntWr[2] && !cntWr[1] |=> cnt_q[2] == $past(cnt_q[2]) + 16'h0001 && cnt_q[1] == 16'h0000;
  endproperty
  a_carry32: assert property (p_carry32) else $error("32-bit carry lost"); // see (R16)

  property p_flag32;
    ctrl_q[1][BIT_CMB] && tick[1] && {cnt_q[2], cnt_q[1]} == {per_q[2], per_q[1]}
      |=> flag_q[2] && !($rose(flag_q[1])) && adc_q && dma_q[1];
  endproperty
  a_flag32: assert property (p_flag32) else $error("32-bit match not flagged"); // see (R19)

  property p_bresp;
    doWrite |=> bvalid_q [*1] ##0 (bresp_q == ($past(wrHit) ? RESP_OKAY : RESP_SLVERR));
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response wrong");

  c_match16: cover property (tick[0] && cnt_q[0] == per_q[0]);
  c_wide_match: cover property (ctrl_q[1][BIT_CMB] && setEvt[2]);
  c_sync_cnt: cover property (mode[0] == MODE_SYNC_CNT && tick[0]);
  c_flag_clr: cover property (flag_q[0] ##1 !flag_q[0]);

endmodule

`default_nettype wire

// ### gpt_pin_model.sv
/*
  Far-side model of the timer block: external clock and gate pins.
  Assumes the bench calls its tasks; pins change just after mclk rises.
*/
`timescale 1ns/1ps
`default_nettype none

module gpt_pin_model
  import gpt_pkg::*;
(
  input wire logic mclk, // Block clock
  output logic [NUM_TMR-1:0] extClkPin, // External clock pins
  output logic [NUM_TMR-1:0] gatePin // Gate levels
);
  initial
  begin
    extClkPin = '0;
    gatePin = '0;
  end

  // One-cycle high pulses; gap keeps the sync path able to follow
  task automatic pulse(input int idx, input int n, input int gap);
    repeat (n)
    begin
      @(posedge mclk);
      extClkPin[idx] <= 1'b1;
      @(posedge mclk);
      extClkPin[idx] <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask

  task automatic setGate(input int idx, input logic v);
    @(posedge mclk);
    gatePin[idx] <= v;
  endtask
endmodule

`default_nettype wire

// ### gpt_timers_bench.sv
/*
  Self-checking bench for gpt_timers: AXI4-Lite tasks, pin model, one
  task per scenario.
  Assumes the register map and bus timing of the designer's note.
*/
`timescale 1ns/1ps
`default_nettype none

module gpt_timers_bench
  import gpt_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic idleMode = 1'b0;
  logic seenClr = 1'b0;
  logic [NUM_TMR-1:0] extClkPin;
  logic [NUM_TMR-1:0] gatePin;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready;
  logic s_axi_wready;
  logic s_axi_bvalid;
  logic s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [NUM_TMR-1:0] tmrFlag;
  logic [3:0] dmaReq;
  logic adcTrig;
  logic [3:0] dmaSeen = '0;
  logic adcSeen = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;

  always #2.5 mclk = ~mclk;

  // Pulses last one cycle, so they are gathered here
  always @(posedge mclk)
  begin
    dmaSeen <= seenClr ? 4'h0 : (dmaSeen | dmaReq);
    adcSeen <= !seenClr && (adcSeen || adcTrig);
  end

  gpt_timers gpt_timers_inst (
    .mclk(mclk), .sys_rst(sys_rst), .idleMode(idleMode),
    .extClkPin(extClkPin), .gatePin(gatePin),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'b000),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'b0011),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'b000), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tmrFlag(tmrFlag),
    .dmaReq(dmaReq), .adcTrig(adcTrig)
  );

  gpt_pin_model gpt_pin_model_inst (
    .mclk(mclk), .extClkPin(extClkPin), .gatePin(gatePin)
  );

  // --------------------------------
  // Bus and compare tasks
  // --------------------------------
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [15:0] d);
    int n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid && n < 40);
    s_axi_bready <= 1'b0;
    check("write answer", 1, s_axi_bvalid);
    check("bresp", RESP_OKAY, s_axi_bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check("read answer", 1, s_axi_rvalid);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(s, e, d);
  endtask

  task automatic waitFlag(input int b);
    int n = 0;
    while (tmrFlag[b] !== 1'b1 && n < 200)
    begin
      @(posedge mclk);
      n++;
    end
    check("flag wait", 1, tmrFlag[b]);
  endtask

  task automatic clrSeen();
    @(posedge mclk);
    seenClr <= 1'b1;
    @(posedge mclk);
    seenClr <= 1'b0;
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic test_reset();
    logic [31:0] d;
    logic [1:0] r;
    rchk(8'h00, 32'h0000_0000, "ctrl0 reset");
    rchk(8'h04, 32'h0000_0000, "count0 reset");
    rchk(8'h28, 32'h0000_FFFF, "period2 reset");
    rd(8'h60, d, r);
    check("unmapped resp", RESP_SLVERR, r);
    check("unmapped data", 0, d);
    w(8'h00, 16'hFFFF);
    rchk(8'h00, {16'h0000, MASK_SOLO}, "ctrl0 bits");
    w(8'h00, 16'h0000);
    $display("test_reset done");
  endtask

  // Odd codes synchronised, even codes not: both counter modes
  task automatic test_prescale();
    int np[4] = '{3, 16, 128, 256};
    int dv[4] = '{1, 8, 64, 256};
    logic [15:0] ctl;
    for (int c = 0; c < 4; c++)
    begin
      ctl = 16'h0002 | 16'(c << 4) | 16'(c % 2 << 2);
      w(8'h00, ctl);
      w(8'h04, 16'h0000);
      w(8'h00, ctl | 16'h8000);
      gpt_pin_model_inst.pulse(0, np[c], 2);
      repeat (8) @(posedge mclk);
      w(8'h00, ctl);
      rchk(8'h04, 32'(np[c] / dv[c]), "prescaled count");
    end
    gpt_pin_model_inst.pulse(0, 3, 2);
    rchk(8'h04, 32'h0000_0001, "stopped count");
    $display("test_prescale done");
  endtask

  task automatic test_sync_write();
    w(8'h00, 16'h0006);
    w(8'h04, 16'h0000);
    w(8'h00, 16'h8006);
    w(8'h04, 16'h1234);
    rchk(8'h04, 32'h0000_0000, "sync write ignored");
    gpt_pin_model_inst.pulse(0, 2, 2);
    rchk(8'h04, 32'h0000_0002, "sync count");
    w(8'h00, 16'h8042);
    w(8'h04, 16'h0055);
    rchk(8'h04, 32'h0000_0055, "async write");
    gpt_pin_model_inst.pulse(0, 4, 2);
    rchk(8'h04, 32'h0000_0059, "gate ignored");
    w(8'h00, 16'h0000);
    $display("test_sync_write done");
  endtask

  task automatic test_idle_gate();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge mclk);
    idleMode <= 1'b1;
    w(8'h04, 16'h0000);
    w(8'h00, 16'hA000);
    repeat (10) @(posedge mclk);
    rchk(8'h04, 32'h0000_0000, "idle halt");
    w(8'h00, 16'h8004);
    rd(8'h04, d, r);
    check("idle run", 1, d != 0);
    @(posedge mclk);
    idleMode <= 1'b0;
    w(8'h00, 16'h0040);
    w(8'h04, 16'h0000);
    w(8'h00, 16'h8040);
    repeat (10) @(posedge mclk);
    rchk(8'h04, 32'h0000_0000, "gate low");
    gpt_pin_model_inst.setGate(0, 1'b1);
    repeat (10) @(posedge mclk);
    rd(8'h04, d, r);
    check("gate high", 1, d != 0);
    w(8'h00, 16'h0000);
    gpt_pin_model_inst.setGate(0, 1'b0);
    w(8'h04, 16'h0000);
    w(8'h00, 16'h8010);
    repeat (80) @(posedge mclk);
    w(8'h00, 16'h0000);
    rchk(8'h04, 32'h0000_000A, "prescale 8 timer");
    $display("test_idle_gate done");
  endtask

  task automatic test_match16();
    logic [31:0] d;
    logic [1:0] r;
    w(8'h50, 16'h001F);
    w(8'h04, 16'h0000);
    w(8'h08, 16'h0003);
    w(8'h34, 16'h0000);
    w(8'h38, 16'h0002);
    clrSeen();
    w(8'h30, 16'h8000);
    w(8'h00, 16'h8000);
    waitFlag(0);
    waitFlag(3);
    w(8'h00, 16'h0000);
    w(8'h30, 16'h0000);
    rd(8'h04, d, r);
    check("count wrapped", 1, d <= 3);
    rchk(8'h50, 32'h0000_0009, "flags 16");
    check("dma 16", 4'b0100, dmaSeen);
    check("adc 16", 0, adcSeen);
    w(8'h50, 16'h0009);
    rchk(8'h50, 32'h0000_0000, "flags cleared");
    $display("test_match16 done");
  endtask

  // Count starts near the carry, so the match needs both words
  task automatic test_pair32();
    w(8'h14, 16'hFFF0);
    w(8'h24, 16'h0000);
    w(8'h18, 16'h0004);
    w(8'h28, 16'h0001);
    w(8'h20, 16'h0030);
    w(8'h10, 16'h0008);
    clrSeen();
    w(8'h10, 16'h8008);
    waitFlag(2);
    w(8'h10, 16'h0008);
    check("low flag quiet", 0, tmrFlag[1]);
    check("dma 32", 4'b0010, dmaSeen);
    check("adc 32", 1, adcSeen);
    rchk(8'h50, 32'h0000_0004, "flags 32");
    rchk(8'h24, 32'h0000_0000, "high word wrapped");
    $display("test_pair32 done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    test_reset();
    test_prescale();
    test_sync_write();
    test_idle_gate();
    test_match16();
    test_pair32();
    stop_test();
  end

  // Tests take about 2100 cycles; nearly twenty times that means a hang
  initial
  begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
endmodule

`default_nettype wire
